// >>> src/e1tsf_formatter.sv
// Overview of operation
// - Non-FAS timeslot 0 holds international bit at bit 0, overhead bits above.
// - Bit 1 of every non-FAS timeslot 0 is always one.
// - Alarm bit 2 is one on receive loss of signal or framing, else zero.
// - National bits 3 to 7 carry data link, only in non-FAS frames.
// - Sixteen frames per CRC multiframe, frame 0 is FAS, types alternate.
// - Frames 0-7 and 8-15 form two sub-multiframes, four FAS each.
// - FAS bit 0 carries check bits in order; bits 1-7 the fixed pattern.
// - Check computed over each sub-multiframe goes into the next one.
// - Non-FAS frames 1,3,5,7,9,11 carry 0,0,1,0,1,1 in bit 0.
// - Non-FAS frames 13 and 15 carry the errored sub-multiframe report bits.
// - CAS multiframe marking only when channel associated signalling is selected.
// - Frame is 32 octet timeslots, 256 bits, timeslot 0 is overhead.
// - Outbound frames alternate strictly between FAS and non-FAS.
module e1tsf_formatter import e1tsf_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Payload octets for timeslots 1 to 31
  input wire logic [7:0] payload_data,
  input wire logic payload_valid,
  output logic payload_ready,
  // Overhead sources from local logic
  input wire logic [4:0] national_bits,
  input wire logic rx_loss_of_signal,
  input wire logic rx_loss_of_framing,
  input wire logic [1:0] rx_errored_smf,
  input wire logic cas_select,
  // Outbound octet stream
  output logic [7:0] tx_data,
  output logic tx_mf_start,
  output logic tx_sub_multiframe,
  output logic tx_cas_mf_mark,
  output logic tx_valid,
  input wire logic tx_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [4:0] ts_q;
  logic [4:0] ts_d;
  logic [3:0] frame_q;
  logic [3:0] frame_d;
  logic ready_q;
  logic ready_d;

  logic is_ts0;
  logic is_fas;
  logic push;
  logic smf_end;
  logic alarm;
  logic si_bit;
  logic [7:0] ts0_octet;
  logic [7:0] push_data;
  logic [7:0] crc_octet;
  logic cas_mark;
  logic mf_start;
  logic [3:0] crc_hold;
  logic buf_in_ready;
  logic buf_space_next;
  logic [E1TSF_BUF_W-1:0] buf_in;
  logic [E1TSF_BUF_W-1:0] buf_out;

  ////////////////////////////////////////////////////////////////////////////
  // Timeslot 0 composition

  always_comb begin
    is_ts0 = (ts_q == E1TSF_TS_OVERHEAD);
    is_fas = !frame_q[0];
    alarm = rx_loss_of_signal || rx_loss_of_framing;
    // Non-FAS bit 0: alignment word first, report bits at the tail
    if (frame_q == E1TSF_FRAME_E_FIRST) begin
      si_bit = rx_errored_smf[0];
    end else if (frame_q == E1TSF_FRAME_E_SECOND) begin
      si_bit = rx_errored_smf[1];
    end else begin
      si_bit = E1TSF_MFAS_PATTERN[frame_q[3:1]];
    end
    if (is_fas) begin
      // Check bit index follows the FAS frame within the sub-multiframe
      ts0_octet = {E1TSF_FAS_PATTERN, crc_hold[2'd3 - frame_q[2:1]]};
    end else begin
      ts0_octet = '0;
      ts0_octet[E1TSF_POS_SI] = si_bit;
      ts0_octet[E1TSF_POS_ONE] = 1'b1;
      ts0_octet[E1TSF_POS_ALARM] = alarm;
      ts0_octet[E1TSF_POS_NAT_LO +: E1TSF_NAT_W] = national_bits;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing and counters

  always_comb begin
    // ready_q already implies buffer room and a payload timeslot
    push = buf_in_ready && (is_ts0 || (payload_valid && ready_q));
    push_data = is_ts0 ? ts0_octet : payload_data;
    // Check positions count as zero inside the divider
    crc_octet = (is_ts0 && is_fas) ? {push_data[7:1], 1'b0} : push_data;
    smf_end = push && (ts_q == E1TSF_TS_LAST) && (frame_q[2:0] == E1TSF_SMF_LAST);
    mf_start = is_ts0 && (frame_q == E1TSF_FRAME_FIRST);
    // No CAS marking at all under common channel signalling
    cas_mark = cas_select && (frame_q == E1TSF_FRAME_FIRST) && (ts_q == E1TSF_TS_CAS);
    ts_d = ts_q;
    frame_d = frame_q;
    if (push) begin
      ts_d = ts_q + 5'h01;
      if (ts_q == E1TSF_TS_LAST) begin
        frame_d = frame_q + 4'h1;
      end
    end
    ready_d = (ts_d != E1TSF_TS_OVERHEAD) && buf_space_next;
    buf_in = {frame_q[3], mf_start, cas_mark, push_data};
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ts_q <= E1TSF_TS_OVERHEAD;
      frame_q <= E1TSF_FRAME_FIRST;
      ready_q <= 1'b0;
    end else begin
      ts_q <= ts_d;
      frame_q <= frame_d;
      ready_q <= ready_d;
    end
  end

  assign payload_ready = ready_q;

  ////////////////////////////////////////////////////////////////////////////
  // Check computation and output buffer

  e1tsf_crc4 u_crc (
    .clk_sys(clk_sys),
    .srst(srst),
    .octet(crc_octet),
    .octet_push(push),
    .smf_end(smf_end),
    .crc_hold_q(crc_hold)
  );

  // Two words deep so a receiver stall never drops an octet
  e1tsf_buf u_buf (
    .clk_sys(clk_sys),
    .srst(srst),
    .in_data(buf_in),
    .in_valid(push),
    .in_ready_q(buf_in_ready),
    .space_next(buf_space_next),
    .out_data_q(buf_out),
    .out_valid_q(tx_valid),
    .out_ready(tx_ready)
  );

  assign tx_data = buf_out[7:0];
  assign tx_cas_mf_mark = buf_out[8];
  assign tx_mf_start = buf_out[9];
  assign tx_sub_multiframe = buf_out[10];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  chk_si_position: assert property (@(posedge clk_sys) disable iff (srst)
    push && is_ts0 && !is_fas && (frame_q == 4'h5) |-> push_data[0] == 1'b1)
    else $error("international bit misplaced in non-FAS octet");

  chk_fixed_one: assert property (@(posedge clk_sys) disable iff (srst)
    push && is_ts0 && frame_q[0] |-> push_data[1] == 1'b1)
    else $error("fixed one missing in non-FAS octet");

  chk_alarm_bit: assert property (@(posedge clk_sys) disable iff (srst)
    push && is_ts0 && frame_q[0]
      |-> push_data[2] == (rx_loss_of_signal | rx_loss_of_framing))
    else $error("remote alarm bit does not follow receive loss");

  chk_nat_bits: assert property (@(posedge clk_sys) disable iff (srst)
    push && is_ts0 && frame_q[0] |-> push_data[7:3] == national_bits)
    else $error("national bits not carried in non-FAS octet");

  chk_mf_first: assert property (@(posedge clk_sys) disable iff (srst)
    push && is_ts0 && frame_q == 4'h0 |-> push_data[7:1] == 7'h6c)
    else $error("multiframe does not open with a FAS frame");

  chk_smf_split: assert property (@(posedge clk_sys) disable iff (srst)
    smf_end |-> frame_q == 4'h7 || frame_q == 4'hf)
    else $error("sub-multiframe boundary at wrong frame");

  chk_fas_pattern: assert property (@(posedge clk_sys) disable iff (srst)
    push && is_ts0 && !frame_q[0] |-> push_data[7:1] == 7'h6c)
    else $error("FAS pattern wrong");

  chk_crc_insert: assert property (@(posedge clk_sys) disable iff (srst)
    push && is_ts0 && frame_q[2:0] == 3'h0 |-> push_data[0] == crc_hold[3])
    else $error("first check bit not taken from previous result");

  chk_crc_last: assert property (@(posedge clk_sys) disable iff (srst)
    push && is_ts0 && frame_q[2:0] == 3'h6 |-> push_data[0] == crc_hold[0])
    else $error("last check bit not taken from previous result");

  chk_mfas_bits: assert property (@(posedge clk_sys) disable iff (srst)
    push && is_ts0 && (frame_q == 4'h1 || frame_q == 4'h3 || frame_q == 4'h7)
      |-> push_data[0] == 1'b0)
    else $error("multiframe alignment zero bit wrong");

  chk_e_bits: assert property (@(posedge clk_sys) disable iff (srst)
    push && is_ts0 && frame_q == 4'hf |-> push_data[0] == rx_errored_smf[1])
    else $error("second report bit wrong");

  chk_cas_gate: assert property (@(posedge clk_sys) disable iff (srst)
    push && buf_in[8] |-> cas_select && ts_q == 5'h10 && frame_q == 4'h0)
    else $error("CAS mark outside selected mode or position");

  chk_ts_wrap: assert property (@(posedge clk_sys) disable iff (srst)
    push && ts_q == 5'h1f |=> ts_q == 5'h00 && frame_q == $past(frame_q) + 4'h1)
    else $error("frame did not close after timeslot 31");

  chk_alternate: assert property (@(posedge clk_sys) disable iff (srst)
    push && ts_q == 5'h1f |=> frame_q[0] != $past(frame_q[0]))
    else $error("frame type did not alternate");

  chk_no_stray_take: assert property (@(posedge clk_sys) disable iff (srst)
    is_ts0 |-> !ready_q)
    else $error("payload offered during timeslot 0");

  chk_mfas_ones: assert property (@(posedge clk_sys) disable iff (srst)
    push && is_ts0 && (frame_q == 4'h5 || frame_q == 4'h9 || frame_q == 4'hb)
      |-> push_data[0] == 1'b1)
    else $error("multiframe alignment one bit wrong");

  chk_e_first: assert property (@(posedge clk_sys) disable iff (srst)
    push && is_ts0 && frame_q == 4'hd |-> push_data[0] == rx_errored_smf[0])
    else $error("first report bit wrong");

  chk_crc_second: assert property (@(posedge clk_sys) disable iff (srst)
    push && is_ts0 && frame_q[2:0] == 3'h2 |-> push_data[0] == crc_hold[2])
    else $error("second check bit not taken from previous result");

  chk_crc_third: assert property (@(posedge clk_sys) disable iff (srst)
    push && is_ts0 && frame_q[2:0] == 3'h4 |-> push_data[0] == crc_hold[1])
    else $error("third check bit not taken from previous result");

  chk_crc_steady: assert property (@(posedge clk_sys) disable iff (srst)
    !smf_end |=> $stable(crc_hold))
    else $error("check result changed inside a sub-multiframe");

  chk_smf_flag: assert property (@(posedge clk_sys) disable iff (srst)
    push |-> buf_in[10] == (frame_q >= 4'h8))
    else $error("sub-multiframe flag wrong");

  chk_mf_flag: assert property (@(posedge clk_sys) disable iff (srst)
    push |-> buf_in[9] == (is_ts0 && frame_q == 4'h0))
    else $error("multiframe start flag wrong");

  chk_cas_present: assert property (@(posedge clk_sys) disable iff (srst)
    push && cas_select && ts_q == 5'h10 && frame_q == 4'h0
      |-> buf_in[8])
    else $error("CAS mark missing in selected mode");

  chk_cas_ccs: assert property (@(posedge clk_sys) disable iff (srst)
    !cas_select |-> !cas_mark)
    else $error("CAS mark under common channel signalling");

  chk_payload_pass: assert property (@(posedge clk_sys) disable iff (srst)
    push && !is_ts0
      |-> payload_valid && push_data == payload_data)
    else $error("payload octet not passed through");

  chk_ts_step: assert property (@(posedge clk_sys) disable iff (srst)
    push && ts_q != 5'h1f
      |=> ts_q == $past(ts_q) + 5'h01 && frame_q == $past(frame_q))
    else $error("timeslot did not step by one");

  chk_count_hold: assert property (@(posedge clk_sys) disable iff (srst)
    !push |=> $stable(ts_q) && $stable(frame_q))
    else $error("counters moved without a push");

  chk_ts0_prompt: assert property (@(posedge clk_sys) disable iff (srst)
    is_ts0 && buf_in_ready |-> push)
    else $error("overhead octet held back with room");

  chk_ready_room: assert property (@(posedge clk_sys) disable iff (srst)
    ready_q |-> buf_in_ready)
    else $error("payload offered without buffer room");

  chk_crc_zeroed: assert property (@(posedge clk_sys) disable iff (srst)
    push && is_ts0 && is_fas
      |-> crc_octet[0] == 1'b0 && crc_octet[7:1] == E1TSF_FAS_PATTERN)
    else $error("check position not zeroed for divider");

  chk_crc_whole: assert property (@(posedge clk_sys) disable iff (srst)
    push && !(is_ts0 && is_fas) |-> crc_octet == push_data)
    else $error("divider input differs from pushed octet");

  chk_type_bit: assert property (@(posedge clk_sys) disable iff (srst)
    push && is_ts0 |-> push_data[1] == frame_q[0])
    else $error("bit 1 does not mark the frame type");

  chk_nat_fas_free: assert property (@(posedge clk_sys) disable iff (srst)
    push && is_ts0 && is_fas
      |-> push_data[7:3] == E1TSF_FAS_PATTERN[6:2])
    else $error("national bits leaked into FAS octet");

endmodule : e1tsf_formatter

// >>> src/e1tsf_pkg.sv
package e1tsf_pkg;

  // Frame geometry
  localparam int unsigned E1TSF_FRAME_BITS = 256;
  localparam int unsigned E1TSF_OCTET_BITS = 8;
  localparam int unsigned E1TSF_TIMESLOTS = E1TSF_FRAME_BITS / E1TSF_OCTET_BITS;
  localparam int unsigned E1TSF_TS_W = $clog2(E1TSF_TIMESLOTS);
  localparam logic [4:0] E1TSF_TS_OVERHEAD = 5'h00;
  localparam logic [4:0] E1TSF_TS_LAST = 5'h1f;
  localparam logic [4:0] E1TSF_TS_CAS = 5'h10;

  // Multiframe geometry
  localparam int unsigned E1TSF_MF_FRAMES = 16;
  localparam int unsigned E1TSF_FRAME_W = $clog2(E1TSF_MF_FRAMES);
  localparam logic [3:0] E1TSF_FRAME_FIRST = 4'h0;
  localparam logic [2:0] E1TSF_SMF_LAST = 3'h7;
  localparam logic [3:0] E1TSF_FRAME_E_FIRST = 4'hd;
  localparam logic [3:0] E1TSF_FRAME_E_SECOND = 4'hf;

  // Timeslot 0 field positions
  localparam int unsigned E1TSF_POS_SI = 0;
  localparam int unsigned E1TSF_POS_ONE = 1;
  localparam int unsigned E1TSF_POS_ALARM = 2;
  localparam int unsigned E1TSF_POS_NAT_LO = 3;
  localparam int unsigned E1TSF_NAT_W = 5;

  // Fixed contents: bits 7..1 of the FAS octet, MFAS bits for frames 1,3,..,11
  localparam logic [6:0] E1TSF_FAS_PATTERN = 7'h6c;
  localparam logic [5:0] E1TSF_MFAS_PATTERN = 6'h34;

  // CRC-4, generator x^4 + x + 1
  localparam int unsigned E1TSF_CRC_W = 4;
  localparam logic [3:0] E1TSF_CRC_POLY = 4'h3;
  localparam logic [3:0] E1TSF_CRC_RESET = 4'h0;

  // Buffer word: {sub_multiframe, mf_start, cas_mark, data}
  localparam int unsigned E1TSF_BUF_W = E1TSF_OCTET_BITS + 3;

endpackage : e1tsf_pkg

// >>> src/e1tsf_crc4.sv
module e1tsf_crc4 import e1tsf_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Octet stream, check positions already zeroed
  input wire logic [7:0] octet,
  input wire logic octet_push,
  input wire logic smf_end,
  // Result of the previous sub-multiframe
  output logic [3:0] crc_hold_q
);

  logic [3:0] acc_q;
  logic [3:0] acc_d;
  logic [3:0] crc_hold_d;
  logic [3:0] next_acc;

  always_comb begin
    next_acc = acc_q;
    for (int i = 0; i < E1TSF_OCTET_BITS; i++) begin
      // Bit 0 goes to line first, so it enters the divider first
      if (octet[i] ^ next_acc[3]) begin
        next_acc = {next_acc[2:0], 1'b0} ^ E1TSF_CRC_POLY;
      end else begin
        next_acc = {next_acc[2:0], 1'b0};
      end
    end
    acc_d = acc_q;
    crc_hold_d = crc_hold_q;
    if (octet_push) begin
      acc_d = next_acc;
      if (smf_end) begin
        crc_hold_d = next_acc;
        acc_d = E1TSF_CRC_RESET;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      acc_q <= E1TSF_CRC_RESET;
      crc_hold_q <= E1TSF_CRC_RESET;
    end else begin
      acc_q <= acc_d;
      crc_hold_q <= crc_hold_d;
    end
  end

  chk_crc_restart: assert property (@(posedge clk_sys) disable iff (srst)
    octet_push && smf_end |=> acc_q == E1TSF_CRC_RESET)
    else $error("crc accumulator not restarted at sub-multiframe end");

endmodule : e1tsf_crc4

// >>> src/e1tsf_buf.sv
module e1tsf_buf import e1tsf_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Fill side
  input wire logic [E1TSF_BUF_W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready_q,
  output logic space_next,
  // Drain side
  output logic [E1TSF_BUF_W-1:0] out_data_q,
  output logic out_valid_q,
  input wire logic out_ready
);

  // Head register drives the outputs directly; spare catches a word during a stall
  logic [E1TSF_BUF_W-1:0] out_data_d;
  logic out_valid_d;
  logic [E1TSF_BUF_W-1:0] spare_q;
  logic [E1TSF_BUF_W-1:0] spare_d;
  logic spare_valid_q;
  logic spare_valid_d;
  logic pop;
  logic push;

  always_comb begin
    pop = out_valid_q && out_ready;
    push = in_valid && in_ready_q;
    out_data_d = out_data_q;
    out_valid_d = out_valid_q;
    spare_d = spare_q;
    spare_valid_d = spare_valid_q;
    if (pop) begin
      if (spare_valid_q) begin
        out_data_d = spare_q;
        spare_valid_d = 1'b0;
      end else begin
        out_valid_d = 1'b0;
      end
    end
    if (push) begin
      if (!out_valid_d) begin
        out_data_d = in_data;
        out_valid_d = 1'b1;
      end else begin
        spare_d = in_data;
        spare_valid_d = 1'b1;
      end
    end
    space_next = !spare_valid_d;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      out_data_q <= '0;
      out_valid_q <= 1'b0;
      spare_q <= '0;
      spare_valid_q <= 1'b0;
      in_ready_q <= 1'b0;
    end else begin
      out_data_q <= out_data_d;
      out_valid_q <= out_valid_d;
      spare_q <= spare_d;
      spare_valid_q <= spare_valid_d;
      in_ready_q <= space_next;
    end
  end

  chk_stall_holds: assert property (@(posedge clk_sys) disable iff (srst)
    out_valid_q && !out_ready |=> out_valid_q && $stable(out_data_q))
    else $error("buffer output changed while stalled");

  chk_full_refuses: assert property (@(posedge clk_sys) disable iff (srst)
    spare_valid_q |-> !in_ready_q)
    else $error("buffer offered room while full");

endmodule : e1tsf_buf

// >>> testbench/e1tsf_rx_model.sv
module e1tsf_rx_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Outbound stream from the formatter
  input wire logic [7:0] tx_data,
  input wire logic tx_mf_start,
  input wire logic tx_sub_multiframe,
  input wire logic tx_cas_mf_mark,
  input wire logic tx_valid,
  output logic tx_ready,
  // Capture control
  input wire logic stall_en,
  output logic [10:0] rx_cnt
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [10:0] rx_mem [0:1023];
  int cyc = 0;

  initial tx_ready = 1'b0;
  initial rx_cnt = 11'h000;

  ////////////////////////////////////////////////////////////////////////////
  // Stalls two cycles in five; stops for good once the capture is full
  always @(negedge clk_sys) begin
    cyc <= cyc + 1;
    tx_ready <= !srst && rx_cnt < 11'h400 && !(stall_en && (cyc % 5) < 2);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word layout matches the buffer: smf, multiframe start, cas mark, data
  always @(posedge clk_sys) begin
    if (srst) begin
      rx_cnt <= 11'h000;
    end else if (tx_valid && tx_ready && rx_cnt < 11'h400) begin
      rx_mem[rx_cnt] <= {tx_sub_multiframe, tx_mf_start, tx_cas_mf_mark, tx_data};
      rx_cnt <= rx_cnt + 11'h001;
    end
  end
endmodule : e1tsf_rx_model

// >>> testbench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] payload_data = 8'h00;
  logic payload_valid = 1'b0;
  logic payload_ready;
  logic [4:0] national_bits = 5'h00;
  logic rx_loss_of_signal = 1'b0;
  logic rx_loss_of_framing = 1'b0;
  logic [1:0] rx_errored_smf = 2'h0;
  logic cas_select = 1'b0;
  logic [7:0] tx_data;
  logic tx_mf_start;
  logic tx_sub_multiframe;
  logic tx_cas_mf_mark;
  logic tx_valid;
  logic tx_ready;
  logic stall_en = 1'b0;
  logic [10:0] rx_cnt;
  logic [10:0] pay_cnt = 11'h000;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;

  always #50 clk_sys = ~clk_sys;

  e1tsf_formatter e1tsf_formatter_i (.clk_sys(clk_sys), .srst(srst),
    .payload_data(payload_data), .payload_valid(payload_valid), .payload_ready(payload_ready),
    .national_bits(national_bits), .rx_loss_of_signal(rx_loss_of_signal),
    .rx_loss_of_framing(rx_loss_of_framing), .rx_errored_smf(rx_errored_smf),
    .cas_select(cas_select), .tx_data(tx_data), .tx_mf_start(tx_mf_start),
    .tx_sub_multiframe(tx_sub_multiframe), .tx_cas_mf_mark(tx_cas_mf_mark),
    .tx_valid(tx_valid), .tx_ready(tx_ready));

  e1tsf_rx_model e1tsf_rx_model_i (.clk_sys(clk_sys), .srst(srst), .tx_data(tx_data),
    .tx_mf_start(tx_mf_start), .tx_sub_multiframe(tx_sub_multiframe),
    .tx_cas_mf_mark(tx_cas_mf_mark), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .stall_en(stall_en), .rx_cnt(rx_cnt));

  ////////////////////////////////////////////////////////////////////////////
  // Payload source: a counting pattern, advanced after each accepted octet
  always @(posedge clk_sys) begin
    if (srst) begin
      pay_cnt <= 11'h000;
    end else if (payload_valid && payload_ready) begin
      pay_cnt <= pay_cnt + 11'h001;
    end
  end
  always @(negedge clk_sys) payload_data <= pay_cnt[7:0] ^ 8'ha5;

  function automatic logic [7:0] pat(input int p);
    return p[7:0] ^ 8'ha5;
  endfunction : pat

  task automatic complete_run();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic cmp_oct(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_oct

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_oct({7'h00, got}, {7'h00, exp});
  endtask : cmp_bit

  ////////////////////////////////////////////////////////////////////////////
  // Rebuilds two multiframes from first principles and checks the capture
  task automatic check_stream(input logic cas);
    logic [3:0] crc;
    logic [3:0] crc_prev;
    logic [7:0] e;
    logic [10:0] w;
    logic [5:0] mfas;
    logic b0;
    int f;
    int ts;
    int p;
    crc = 4'h0;
    crc_prev = 4'h0;
    mfas = 6'h34;
    p = 0;
    for (int k = 0; k < 1024; k++) begin
      f = (k / 32) % 16;
      ts = k % 32;
      w = e1tsf_rx_model_i.rx_mem[k];
      if (ts != 0) begin
        e = pat(p);
        p++;
        cmp_oct(w[7:0], e);
      end else if (f % 2 == 0) begin
        e = {7'h6c, crc_prev[3 - (f % 8) / 2]};
        cmp_oct(w[7:0], e);
        e[0] = 1'b0;
      end else begin
        b0 = (f == 13) ? rx_errored_smf[0] : (f == 15) ? rx_errored_smf[1] : mfas[f / 2];
        e = {national_bits, rx_loss_of_signal | rx_loss_of_framing, 1'b1, b0};
        cmp_oct(w[7:0], e);
      end
      cmp_bit(w[9], f == 0 && ts == 0);
      cmp_bit(w[10], f >= 8);
      cmp_bit(w[8], cas && f == 0 && ts == 16);
      // Serial order is bit 0 first, check positions already zeroed
      for (int i = 0; i < 8; i++) begin
        crc = {crc[2:0], 1'b0} ^ ((e[i] ^ crc[3]) ? 4'h3 : 4'h0);
      end
      if (k % 256 == 255) begin
        crc_prev = crc;
        crc = 4'h0;
      end
    end
  endtask : check_stream

  task automatic run_case(input logic [4:0] nat, input logic los, input logic lof,
                          input logic [1:0] err, input logic cas, input logic stall);
    int i;
    @(negedge clk_sys);
    srst = 1'b1;
    national_bits = nat;
    rx_loss_of_signal = los;
    rx_loss_of_framing = lof;
    rx_errored_smf = err;
    cas_select = cas;
    stall_en = stall;
    payload_valid = 1'b1;
    repeat (12) @(negedge clk_sys);
    cmp_bit(tx_valid, 1'b0);
    srst = 1'b0;
    for (i = 0; i < 6000 && rx_cnt !== 11'h400; i++) @(negedge clk_sys);
    // Receiver now stalls for good, so the source must be refused
    repeat (40) @(negedge clk_sys);
    cmp_bit(payload_ready, 1'b0);
    check_stream(cas);
  endtask : run_case

  task automatic test_clear_cas();
    run_case(5'h15, 1'b0, 1'b0, 2'h0, 1'b1, 1'b1);
  endtask : test_clear_cas

  task automatic test_signal_loss();
    run_case(5'h0a, 1'b1, 1'b0, 2'h1, 1'b0, 1'b0);
  endtask : test_signal_loss

  task automatic test_framing_loss();
    run_case(5'h1f, 1'b0, 1'b1, 2'h2, 1'b1, 1'b1);
  endtask : test_framing_loss

  initial begin
    test_clear_cas();
    test_signal_loss();
    test_framing_loss();
    complete_run();
  end
endmodule : tb_top
